// ===== filt_end.sv
`default_nettype none
`default_nettype wire

// ===== filt_pkg.sv
`default_nettype none
package filt_pkg;
  // Coefficient byte addresses of the IIR set.
  localparam logic [7:0] IIR_LEAD_NUM = 8'h08;
  localparam logic [7:0] IIR_DELAY_NUM = 8'h0a;
  localparam logic [7:0] IIR_FEEDBACK = 8'h0c;
  // Coefficient byte addresses of the biquad sets.
  localparam logic [7:0] BQ_A_LEAD_NUM = 8'h0e;
  localparam logic [7:0] BQ_A_MID_NUM = 8'h10;
  localparam logic [7:0] BQ_A_LAST_NUM = 8'h12;
  localparam logic [7:0] BQ_A_FB_FIRST = 8'h14;
  localparam logic [7:0] BQ_A_FB_SECOND = 8'h16;
  localparam logic [7:0] BQ_B_LEAD_NUM = 8'h18;
  localparam logic [7:0] BQ_B_MID_NUM = 8'h1a;
  localparam logic [7:0] BQ_B_LAST_NUM = 8'h1c;
  localparam logic [7:0] BQ_B_FB_FIRST = 8'h1e;
  localparam logic [7:0] BQ_B_FB_SECOND = 8'h20;
  localparam logic [7:0] BQ_C_LEAD_NUM = 8'h22;
  localparam logic [7:0] BQ_C_MID_NUM = 8'h24;
  localparam logic [7:0] BQ_C_LAST_NUM = 8'h26;
  localparam logic [7:0] BQ_C_FB_FIRST = 8'h28;
  localparam logic [7:0] BQ_C_FB_SECOND = 8'h2a;
  localparam logic [7:0] BQ_D_LEAD_NUM = 8'h2c;
  localparam logic [7:0] BQ_D_MID_NUM = 8'h2e;
  localparam logic [7:0] BQ_D_LAST_NUM = 8'h30;
  localparam logic [7:0] BQ_D_FB_FIRST = 8'h32;
  localparam logic [7:0] BQ_D_FB_SECOND = 8'h34;
  localparam logic [7:0] BQ_E_LEAD_NUM = 8'h36;
  localparam logic [7:0] BQ_E_MID_NUM = 8'h38;
  localparam logic [7:0] BQ_E_LAST_NUM = 8'h3a;
  localparam logic [7:0] BQ_E_FB_FIRST = 8'h3c;
  localparam logic [7:0] BQ_E_FB_SECOND = 8'h3e;
  // Last mapped byte address.
  localparam logic [7:0] COEF_LAST_ADDR = 8'h3f;
  // Storage layout in 16-bit words.
  localparam int NUM_COEF = 28;
  localparam int NUM_BQ = 5;
  localparam int BQ_STRIDE = 5;
  localparam int BQ_BASE = 3;
  localparam int FIR_BASE = 3;
  localparam int FIR_LONG = 25;
  localparam int FIR_SHORT = 20;
  localparam int BQ_SHORT = 3;
  localparam int FRAC_BITS = 15;
  // Values after reset, and the clip limits of one sample.
  localparam logic [15:0] LEAD_RESET = 16'h7fff;
  localparam logic [15:0] OTHER_RESET = 16'h0000;
  localparam logic signed [39:0] SAMPLE_MAX = 40'sh00_0000_7fff;
  localparam logic signed [39:0] SAMPLE_MIN = -40'sh00_0000_8000;
  // Processing block selection codes.
  localparam logic [3:0] BLOCK_IIR_A = 4'h0;
  localparam logic [3:0] BLOCK_BQ5_A = 4'h1;
  localparam logic [3:0] BLOCK_25TAP_ALPHA = 4'h2;
  localparam logic [3:0] BLOCK_IIR_B = 4'h3;
  localparam logic [3:0] BLOCK_BQ3_B = 4'h4;
  localparam logic [3:0] BLOCK_20TAP_BETA = 4'h5;
  localparam logic [3:0] BLOCK_IIR_C = 4'h6;
  localparam logic [3:0] BLOCK_BQ5_C = 4'h7;
  localparam logic [3:0] BLOCK_25TAP_GAMMA = 4'h8;
  // Sequencer states.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_IIR = 3'b001,
    ST_BQ = 3'b010,
    ST_FIR = 3'b011,
    ST_OUT = 3'b100
  } stage_t;
endpackage
`default_nettype wire

// ===== filt_stage.sv
`default_nettype none

// Small synchronous FIFO; readiness and validity are registered flags.
module sample_fifo #(
  parameter int W = 16,
  parameter int D = 8
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_n,
  // Filling side.
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  // Draining side.
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(D);

  generate
    if (D < 2 || (1 << AW) != D || W < 1) begin : g_bad
      $error("sample_fifo needs a power-of-two depth of at least 2.");
    end
  endgenerate

  logic [W-1:0] mem [D]; // Sample storage.
  logic [AW-1:0] wr_ptr; // Next slot to fill.
  logic [AW-1:0] rd_ptr; // Oldest slot.
  logic [AW:0] count; // Words held.
  logic push;
  logic pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr];

  // Data array has no reset; a word is only read after it was written.
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers, count and the two registered flags move together.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
        in_ready <= (count + 1'b1) != (AW + 1)'(D);
        out_valid <= 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
        in_ready <= 1'b1;
        out_valid <= count != (AW + 1)'(1);
      end else begin
        // Ready rises one cycle after reset so nothing is taken in reset.
        in_ready <= count != (AW + 1)'(D);
      end
    end
  end
endmodule

module adc_filter_stage #(
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_n,
  // Coefficient page byte access.
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Processing block selection.
  input wire logic [3:0] block_sel,
  // Samples from the decimation chain.
  input wire logic in_valid,
  input wire logic [15:0] in_data,
  output logic in_ready,
  // Filtered samples toward the serial interface.
  output logic out_valid,
  output logic [15:0] out_data,
  input wire logic out_ready
);
  import filt_pkg::*;

  // True for a word that is a leading numerator.
  function automatic logic is_lead(input int i);
    return (i == 0) || (i >= BQ_BASE && (i - BQ_BASE) % BQ_STRIDE == 0);
  endfunction

  // Biquad count of a processing block.
  function automatic int bq_count(input logic [3:0] b);
    if (b == BLOCK_BQ5_A || b == BLOCK_BQ5_C) begin
      return NUM_BQ;
    end else if (b == BLOCK_BQ3_B) begin
      return BQ_SHORT;
    end
    return 0;
  endfunction

  // FIR tap count of a processing block.
  function automatic int fir_taps(input logic [3:0] b);
    if (b == BLOCK_25TAP_ALPHA || b == BLOCK_25TAP_GAMMA) begin
      return FIR_LONG;
    end else if (b == BLOCK_20TAP_BETA) begin
      return FIR_SHORT;
    end
    return 0;
  endfunction

  // Scale a 1.15 product sum back and clip to one sample.
  function automatic logic signed [15:0] scale_sat(
    input logic signed [39:0] a
  );
    logic signed [39:0] s;
    s = a >>> FRAC_BITS;
    if (s > SAMPLE_MAX) begin
      return SAMPLE_MAX[15:0];
    end else if (s < SAMPLE_MIN) begin
      return SAMPLE_MIN[15:0];
    end
    return s[15:0];
  endfunction

  logic [15:0] coef [NUM_COEF]; // Coefficient words, 1.15 signed.
  logic [4:0] widx; // Word index of the addressed byte.
  logic in_map; // Address falls inside coefficient storage.
  logic fifo_valid; // A sample is waiting for the engine.
  logic [15:0] fifo_data;
  logic fifo_pop;
  stage_t state; // Sequencer position.
  logic [3:0] blk; // Block latched for the current sample.
  logic signed [15:0] x_cur; // Sample moving through the chain.
  logic signed [15:0] iir_x1; // IIR previous input.
  logic signed [15:0] iir_y1; // IIR previous output.
  logic signed [15:0] bq_x1 [NUM_BQ];
  logic signed [15:0] bq_x2 [NUM_BQ];
  logic signed [15:0] bq_y1 [NUM_BQ];
  logic signed [15:0] bq_y2 [NUM_BQ];
  logic signed [15:0] fir_dl [FIR_LONG]; // Past FIR inputs, newest first.
  logic [2:0] bq_i; // Biquad being run.
  logic [4:0] tap; // FIR tap being accumulated.
  logic signed [39:0] fir_acc; // FIR running sum.
  logic signed [15:0] iir_y; // IIR result this cycle.
  logic signed [15:0] bq_y; // Biquad result this cycle.
  logic signed [39:0] tap_sum; // FIR sum including this tap.
  int cb; // First word of the running biquad set.

  assign widx = 5'((reg_addr - IIR_LEAD_NUM) >> 1);
  assign in_map = reg_addr >= IIR_LEAD_NUM && reg_addr <= COEF_LAST_ADDR;
  assign fifo_pop = fifo_valid && state == ST_IDLE;

  // Buffer between the decimation chain and the engine; a stalled output
  // fills it and then drops in_ready toward the source.
  sample_fifo #(
    .W(16),
    .D(FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .rst_n(rst_n),
    .in_valid(in_valid),
    .in_data(in_data),
    .in_ready(in_ready),
    .out_valid(fifo_valid),
    .out_data(fifo_data),
    .out_ready(fifo_pop)
  );

  // Host writes land in the addressed byte; reset restores all-pass sets.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_COEF; i++) begin
        coef[i] <= is_lead(i) ? LEAD_RESET : OTHER_RESET;
      end
    end else if (reg_wr && in_map) begin
      if (reg_addr[0]) begin
        coef[widx][7:0] <= reg_wdata;
      end else begin
        coef[widx][15:8] <= reg_wdata;
      end
    end
  end

  // Read data is registered; unmapped addresses read zero.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (!in_map) begin
        reg_rdata <= 8'h00;
      end else if (reg_addr[0]) begin
        reg_rdata <= coef[widx][7:0];
      end else begin
        reg_rdata <= coef[widx][15:8];
      end
    end
  end

  // First-order section; reset values give 0x7fff/2^15, just below unity.
  // The 2^15 denominator is the final shift, so no divider is needed.
  always_comb begin
    iir_y = scale_sat(40'($signed(coef[0]) * x_cur)
      + 40'($signed(coef[1]) * iir_x1)
      + 40'($signed(coef[2]) * iir_y1));
  end

  // One biquad per cycle; the set is chosen by bq_i.
  always_comb begin
    cb = BQ_BASE + BQ_STRIDE * int'(bq_i);
    bq_y = scale_sat(40'($signed(coef[cb]) * x_cur)
      + (40'($signed(coef[cb + 1]) * bq_x1[bq_i]) <<< 1)
      + 40'($signed(coef[cb + 2]) * bq_x2[bq_i])
      + (40'($signed(coef[cb + 3]) * bq_y1[bq_i]) <<< 1)
      + 40'($signed(coef[cb + 4]) * bq_y2[bq_i]));
  end

  // Tap 0 uses the new sample; later taps use the delay line.
  always_comb begin
    if (tap == 5'd0) begin
      tap_sum = fir_acc + 40'($signed(coef[FIR_BASE]) * x_cur);
    end else begin
      tap_sum = fir_acc + 40'($signed(coef[FIR_BASE + int'(tap)])
        * fir_dl[tap - 5'd1]);
    end
  end

  // Sequencer: IIR, then biquads or FIR as the block allows, then output.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      blk <= BLOCK_IIR_A;
      x_cur <= '0;
      bq_i <= '0;
      tap <= '0;
      fir_acc <= '0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (fifo_valid) begin
            x_cur <= $signed(fifo_data);
            blk <= block_sel;
            state <= ST_IIR;
          end
        end
        ST_IIR: begin
          x_cur <= iir_y;
          bq_i <= '0;
          tap <= '0;
          fir_acc <= '0;
          if (bq_count(blk) > 0) begin
            state <= ST_BQ;
          end else if (fir_taps(blk) > 0) begin
            state <= ST_FIR;
          end else begin
            state <= ST_OUT;
          end
        end
        ST_BQ: begin
          x_cur <= bq_y;
          bq_i <= bq_i + 3'd1;
          if (int'(bq_i) == bq_count(blk) - 1) begin
            state <= ST_OUT;
          end
        end
        ST_FIR: begin
          fir_acc <= tap_sum;
          tap <= tap + 5'd1;
          if (int'(tap) == fir_taps(blk) - 1) begin
            x_cur <= scale_sat(tap_sum);
            state <= ST_OUT;
          end
        end
        ST_OUT: begin
          if (out_valid && out_ready) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // IIR history moves once per sample.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      iir_x1 <= '0;
      iir_y1 <= '0;
    end else if (state == ST_IIR) begin
      iir_x1 <= x_cur;
      iir_y1 <= iir_y;
    end
  end

  // Biquad histories; a set only moves when it runs.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int k = 0; k < NUM_BQ; k++) begin
        bq_x1[k] <= '0;
        bq_x2[k] <= '0;
        bq_y1[k] <= '0;
        bq_y2[k] <= '0;
      end
    end else if (state == ST_BQ) begin
      bq_x1[bq_i] <= x_cur;
      bq_x2[bq_i] <= bq_x1[bq_i];
      bq_y1[bq_i] <= bq_y;
      bq_y2[bq_i] <= bq_y1[bq_i];
    end
  end

  // FIR line shifts after the last tap, so every tap saw the old line.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int n = 0; n < FIR_LONG; n++) begin
        fir_dl[n] <= '0;
      end
    end else if (state == ST_FIR && int'(tap) == fir_taps(blk) - 1) begin
      fir_dl[0] <= x_cur;
      for (int n = 1; n < FIR_LONG; n++) begin
        fir_dl[n] <= fir_dl[n - 1];
      end
    end
  end

  // Output register holds the sample until the sink takes it.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      out_valid <= 1'b0;
      out_data <= 16'h0000;
    end else if (state == ST_OUT && !out_valid) begin
      out_valid <= 1'b1;
      out_data <= x_cur;
    end else if (out_valid && out_ready) begin
      out_valid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== filt_stage_properties.sv
`default_nettype none
// Port-level checks of the filter stage's handshakes and register port.
module filt_stage_checker #(
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_n,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Sample streams.
  input wire logic [3:0] block_sel,
  input wire logic in_valid,
  input wire logic [15:0] in_data,
  input wire logic in_ready,
  input wire logic out_valid,
  input wire logic [15:0] out_data,
  input wire logic out_ready
);
  timeunit 1ns;
  timeprecision 100ps;
  // Samples taken in but not yet handed on.
  int pending;
  logic acc;
  logic take;
  assign acc = in_valid && in_ready;
  assign take = out_valid && out_ready;
  // The count lets latency and capacity be judged without internal state.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pending <= 0;
    end else begin
      pending <= pending + int'(acc) - int'(take);
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Three quiet cycles, then the result.
  sequence quiet_then_out;
    !out_valid [*3] ##1 out_valid;
  endsequence
  a_out_hold: assert property (
    out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("output changed while stalled");
  a_out_drop: assert property (
    take |=> !out_valid) else $error("output stayed after handover");
  a_iir_latency: assert property (
    acc && pending == 0 && block_sel == 4'h0 |=> quiet_then_out)
    else $error("filter latency wrong");
  a_pending_cap: assert property (
    pending <= FIFO_DEPTH + 1) else $error("too many samples held");
  a_idle_quiet: assert property (
    pending == 0 |-> !out_valid) else $error("output without input");
  a_rd_unmapped: assert property (
    reg_rd && !(reg_addr inside {[8'h08:8'h3f]}) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property (
    !reg_rd |=> $stable(reg_rdata)) else $error("read data moved");
  a_wr_readback: assert property (
    reg_wr && reg_addr inside {[8'h08:8'h3f]} ##1
    reg_rd && !reg_wr && $stable(reg_addr) |=>
    reg_rdata == $past(reg_wdata, 2)) else $error("readback wrong");
  c_fill: cover property (!in_ready && pending > 0);
  c_stall: cover property (out_valid && !out_ready);
  c_readback: cover property (reg_wr ##1 reg_rd);
endmodule
bind adc_filter_stage filt_stage_checker #(.FIFO_DEPTH(FIFO_DEPTH)) chk (
  .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .block_sel(block_sel), .in_valid(in_valid), .in_data(in_data),
  .in_ready(in_ready), .out_valid(out_valid), .out_data(out_data),
  .out_ready(out_ready));
`default_nettype wire

// ===== sample_sink.sv
`default_nettype none
// Stands in for the serial side that drains filtered samples.
module sample_sink (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_n,
  // Hold-off request from the bench.
  input wire logic stall,
  // Filtered sample stream.
  input wire logic out_valid,
  input wire logic [15:0] out_data,
  output logic out_ready,
  // Record of what was taken.
  output logic [15:0] n_got,
  output logic [15:0] last_data
);
  timeunit 1ns;
  timeprecision 100ps;
  // Ready drops while stalled, so the stage must hold its output.
  assign out_ready = !stall;
  // Records each sample on the edge where it is handed over.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      n_got <= 16'h0000;
      last_data <= 16'h0000;
    end else if (out_valid && out_ready) begin
      n_got <= n_got + 16'h0001;
      last_data <= out_data;
    end
  end
endmodule
`default_nettype wire

// ===== tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import filt_pkg::*;
  localparam int DEPTH = 8;
  // Design inputs, all given a value at time zero.
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_rd = 1'b0;
  logic [3:0] block_sel = 4'h0;
  logic in_valid = 1'b0;
  logic [15:0] in_data = 16'h0000;
  logic stall = 1'b0;
  logic [7:0] reg_rdata;
  logic in_ready;
  logic out_valid;
  logic out_ready;
  logic [15:0] out_data;
  logic [15:0] n_got;
  logic [15:0] last_data;
  int n_mismatch = 0;
  int checks_done = 0;
  int n_recv = 0;
  // Memoryless cases: block, sample, and stages of 32767/32768 gain.
  typedef struct {logic [3:0] blk; logic [15:0] x; int stages;} row_t;
  row_t rows [8] = '{'{BLOCK_IIR_A, 16'h4000, 1}, '{BLOCK_IIR_B, 16'hc000, 1},
    '{BLOCK_IIR_C, 16'h8000, 1}, '{4'h9, 16'h7fff, 1},
    '{BLOCK_BQ5_A, 16'h4000, 6}, '{BLOCK_BQ5_C, 16'h8000, 6},
    '{BLOCK_BQ3_B, 16'hc000, 4}, '{4'hf, 16'h1234, 1}};
  logic [7:0] zero_bytes [8] = '{8'h18, 8'h19, 8'h22, 8'h23, 8'h2c, 8'h2d,
    8'h36, 8'h37};
  logic [3:0] fir_blk [3] = '{BLOCK_25TAP_ALPHA, BLOCK_20TAP_BETA,
    BLOCK_25TAP_GAMMA};
  always #12.5 mclk = ~mclk;
  adc_filter_stage #(.FIFO_DEPTH(DEPTH)) uut (.mclk(mclk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .block_sel(block_sel),
    .in_valid(in_valid), .in_data(in_data), .in_ready(in_ready),
    .out_valid(out_valid), .out_data(out_data), .out_ready(out_ready));
  sample_sink sink (.mclk(mclk), .rst_n(rst_n), .stall(stall),
    .out_valid(out_valid), .out_data(out_data), .out_ready(out_ready),
    .n_got(n_got), .last_data(last_data));
  // Reset-value gain applied n times, flooring as the stage does.
  function automatic logic [15:0] gain_n(input logic [15:0] x, input int n);
    logic signed [31:0] y;
    y = {{16{x[15]}}, x};
    repeat (n) y = (y * 32'sd32767) >>> 15;
    return y[15:0];
  endfunction
  task automatic cmp8(input string what, input logic [7:0] e, logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic cmp16(input string what, logic [15:0] e, logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic stop_test();
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Tasks start just after a rising edge and drive by non-blocking writes.
  task automatic do_reset();
    rst_n <= 1'b0;
    n_recv = 0;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (2) @(posedge mclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(posedge mclk);
    cmp8("reg_rdata", e, reg_rdata);
  endtask
  // A read straight after the write shows the new byte at once.
  task automatic wr_rd(input logic [7:0] a, logic [7:0] d, logic [7:0] e);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    rd(a, e);
  endtask
  task automatic wr_word(input logic [7:0] a, input logic [15:0] w);
    wr_rd(a, w[15:8], w[15:8]);
    wr_rd(a + 8'h01, w[7:0], w[7:0]);
  endtask
  task automatic send(input logic [15:0] x);
    logic ok = 1'b0;
    in_valid <= 1'b1;
    in_data <= x;
    for (int i = 0; i < 60 && !ok; i++) begin
      @(negedge mclk);
      ok = (in_ready === 1'b1);
      @(posedge mclk);
    end
    in_valid <= 1'b0;
  endtask
  task automatic recv(input logic [15:0] e);
    n_recv++;
    for (int i = 0; i < 300 && n_got !== 16'(n_recv); i++) @(negedge mclk);
    @(posedge mclk);
    // A sample that never arrived counts as a mismatch here.
    cmp16("n_got", 16'(n_recv), n_got);
    cmp16("out_data", e, last_data);
  endtask
  initial begin
    int n_acc;
    logic ok;
    do_reset();
    // Reset contents, high byte at the even address.
    for (int a = 8; a < 64; a++) begin
      ok = ((a | 1) - 15) % 10 == 0 || (a | 1) == 9;
      rd(8'(a), ok ? (a % 2 ? 8'hff : 8'h7f) : 8'h00);
    end
    wr_rd(8'h40, 8'h5a, 8'h00);
    wr_rd(8'h07, 8'h5a, 8'h00);
    foreach (rows[i]) begin
      block_sel <= rows[i].blk;
      send(rows[i].x);
      recv(gain_n(rows[i].x, rows[i].stages));
    end
    // Delay numerator and feedback both at one half.
    do_reset();
    wr_word(8'h0a, 16'h4000);
    wr_word(8'h0c, 16'h4000);
    foreach (rows[i]) begin
      if (i < 3) begin
        send(i == 0 ? 16'h4000 : 16'h0000);
        recv(i == 2 ? 16'h1fff : 16'h3fff);
      end
    end
    // Middle numerator of the first biquad counts twice.
    do_reset();
    block_sel <= BLOCK_BQ3_B;
    wr_word(BQ_A_MID_NUM, 16'h2000);
    send(16'h4000);
    recv(gain_n(16'h4000, 4));
    send(16'h0000);
    recv(gain_n(16'd8191, 2));
    // Taps share biquad storage; make it all-pass, then add two taps.
    do_reset();
    foreach (zero_bytes[i]) wr_rd(zero_bytes[i], 8'h00, 8'h00);
    wr_word(8'h34, 16'h2000);
    wr_word(8'h3e, 16'h4000);
    foreach (fir_blk[i]) begin
      block_sel <= fir_blk[i];
      for (int k = 0; k < 25; k++) begin
        send(k == 0 ? 16'h4000 : 16'h0000);
        recv(k == 0 ? 16'd16382 : k == 19 ? 16'd4095 :
          (k == 24 && fir_blk[i] != BLOCK_20TAP_BETA) ? 16'd8191 :
          16'd0);
      end
    end
    // Fill while the sink stalls, then drain in order.
    do_reset();
    block_sel <= BLOCK_IIR_A;
    stall <= 1'b1;
    in_valid <= 1'b1;
    n_acc = 0;
    ok = 1'b1;
    while (ok && n_acc < 20) begin
      in_data <= 16'(16'h0100 * (n_acc + 1));
      @(negedge mclk);
      ok = (in_ready === 1'b1);
      @(posedge mclk);
      if (ok) n_acc++;
    end
    in_valid <= 1'b0;
    cmp16("accepted", 16'(DEPTH + 1), 16'(n_acc));
    repeat (4) @(posedge mclk);
    stall <= 1'b0;
    for (int k = 0; k < n_acc; k++) begin
      recv(gain_n(16'(16'h0100 * (k + 1)), 1));
    end
    stop_test();
  end
  // Whole run is a few thousand cycles; this cuts a hang short.
  initial begin
    #(25 * 20000);
    n_mismatch++;
    stop_test();
  end
endmodule
`default_nettype wire
